// *** cpm_mode_ctrl.sv ***
// Mode selection, discharge sequencing and data-only fallback of the charging port controller.
//
// Operation
// - Reset holds initial state and output discharge.
// - After reset, follow the mode pins.
// - Pins 100: forced shorted, limit by pick.
// - Pins 101: forced divider one, limit by pick.
// - Pins 001 pick high: wake/high auto limit.
// - Pins 001 pick high: power-wake load status.
// - Pins 011: auto high, non-wake load status with pick high.
// - All high: downstream charging, high, status.
// - 1111 and 1110 swap without discharge.
// - Discharge: switch off, then back on.
// - Long discharge from a data mode into auto, short otherwise.
// - Detect phone that made no data connection.
// - Then discharge and become data-only port.
// - Return to downstream charging without discharge.
// - Three limits (low, high, wake), chosen by pin decode and power-wake load.
// - Data switches open during discharge.
// - Data switches close only with enable high.
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
module cpm_mode_ctrl
(
   // Clock and reset.
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Control pins from the host system.
   input  wire cpm_pkg::cpm_pins_t   pins,
   input  wire logic                 enable,
   // Detection inputs from the analog front end.
   input  wire logic                 load_present_pw,
   input  wire logic                 load_present_npw,
   input  wire logic                 primary_detect,
   input  wire logic                 data_attach,
   // Port control outputs.
   output cpm_pkg::cpm_port_out_t    port_out,
   output cpm_pkg::cpm_mode_t        mode,
   output logic                      irq,
   // Avalon-MM slave.
   input  wire logic [4:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest
);
   import cpm_pkg::*;

   typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_DCHG} cpm_state_t;

   logic            rst_meta_r;
   logic            rst_sync_n;
   cpm_state_t      state_r;
   cpm_mode_t       cur_mode_r;
   cpm_mode_t       tgt_mode_r;
   cpm_mode_t       prev_mode_r;
   cpm_mode_t       req_mode;
   cpm_mode_t       want_mode;
   logic            pw_sel;
   logic            npw_sel;
   logic            cur_data_mode;
   logic            need_dchg;
   logic            tmr_start;
   logic            tmr_long;
   logic            tmr_busy;
   logic            tmr_done;
   logic            fb_en_r;
   logic            fb_active_r;
   logic            fb_return_r;
   logic            pd_seen_r;
   logic [9:0]      fb_cnt_r;
   logic            fb_trig;
   cpm_port_out_t   out_nxt;
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_en_r;
   logic [IRQ_W-1:0] irq_ev;
   logic            rd_done_r;
   logic [31:0]     rd_nxt;
   logic            wr_clr;

   // Reset is released through two flip-flops.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_n <= rst_meta_r;
      end
   end

   // Decode of the control pins into the requested mode.
   always_comb
   begin
      case ({pins.mode_select_a, pins.mode_select_b, pins.mode_select_c})
         3'h0:    req_mode = MD_DISCHARGE;
         3'h1:    req_mode = MD_AUTO_DCP;
         3'h3:    req_mode = MD_AUTO_DCP;
         3'h4:    req_mode = MD_SHORTED;
         3'h5:    req_mode = MD_DIVIDER_ONE_SCHEME;
         3'h7:    req_mode = pins.limit_pick ? MD_CDP : MD_SDP_B;
         default: req_mode = MD_SDP_A;
      endcase
      want_mode = (fb_active_r && req_mode == MD_CDP) ? MD_SDP_A : req_mode;
   end

   assign pw_sel  = pins == 4'h3;
   assign npw_sel = pins == 4'h7;
   assign cur_data_mode = (cur_mode_r == MD_SDP_A) || (cur_mode_r == MD_SDP_B) || (cur_mode_r == MD_CDP);

   // Leaving or entering the discharge mode needs no timed discharge.
   always_comb
   begin
      need_dchg = 1'b1;
      if (cur_mode_r == MD_DISCHARGE || want_mode == MD_DISCHARGE)
         need_dchg = 1'b0;
      else if ((cur_mode_r == MD_SDP_B && want_mode == MD_CDP) || (cur_mode_r == MD_CDP && want_mode == MD_SDP_B))
         need_dchg = 1'b0;
      else if (fb_return_r && cur_mode_r == MD_SDP_A && want_mode == MD_CDP)
         need_dchg = 1'b0;
   end

   assign tmr_start = (state_r == ST_RUN) && (want_mode != cur_mode_r) && need_dchg;
   assign tmr_long  = cur_data_mode && (want_mode == MD_AUTO_DCP);

   cpm_dchg_timer u_timer
   (
      .clk      (clk),
      .rst_n    (rst_sync_n),
      .start    (tmr_start),
      .long_sel (tmr_long),
      .busy     (tmr_busy),
      .done     (tmr_done)
   );

   // Main sequencer.
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         state_r    <= ST_INIT;
         cur_mode_r <= MD_DISCHARGE;
         tgt_mode_r <= MD_DISCHARGE;
      end
      else
      begin
         case (state_r)
            ST_INIT:
               state_r <= ST_RUN;
            ST_RUN:
               if (tmr_start)
               begin
                  state_r    <= ST_DCHG;
                  tgt_mode_r <= want_mode;
               end
               else if (want_mode != cur_mode_r)
                  cur_mode_r <= want_mode;
            ST_DCHG:
               if (tmr_done)
               begin
                  state_r    <= ST_RUN;
                  cur_mode_r <= tgt_mode_r;
               end
            default:
               state_r <= ST_INIT;
         endcase
      end
   end

   // Watch for a phone that took the downstream port for charging only.
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         pd_seen_r <= 1'b0;
         fb_cnt_r  <= 10'h000;
      end
      else if (state_r != ST_RUN || cur_mode_r != MD_CDP || !fb_en_r || data_attach)
      begin
         pd_seen_r <= 1'b0;
         fb_cnt_r  <= 10'h000;
      end
      else
      begin
         if (primary_detect)
            pd_seen_r <= 1'b1;
         if (pd_seen_r && fb_cnt_r != FB_WAIT_CNT)
            fb_cnt_r <= fb_cnt_r + 10'h001;
      end
   end

   assign fb_trig = pd_seen_r && (fb_cnt_r == FB_WAIT_CNT - 10'h001);

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         fb_active_r <= 1'b0;
         fb_return_r <= 1'b0;
      end
      else
      begin
         if (fb_trig)
            fb_active_r <= 1'b1;
         else if (req_mode != MD_CDP)
            fb_active_r <= 1'b0;
         else if (fb_active_r && state_r == ST_RUN && cur_mode_r == MD_SDP_A && data_attach)
            fb_active_r <= 1'b0;
         if (fb_active_r && state_r == ST_RUN && cur_mode_r == MD_SDP_A && data_attach && req_mode == MD_CDP)
            fb_return_r <= 1'b1;
         else if (cur_mode_r == MD_CDP || req_mode != MD_CDP)
            fb_return_r <= 1'b0;
      end
   end

   // Port outputs follow the settled mode.
   always_comb
   begin
      out_nxt = '0;
      out_nxt.power_switch_on = (state_r == ST_RUN) && (cur_mode_r != MD_DISCHARGE);
      out_nxt.discharge_on    = !out_nxt.power_switch_on;
      out_nxt.data_switch_on  = out_nxt.power_switch_on && enable && cur_data_mode;
      out_nxt.status_n        = 1'b1;
      out_nxt.current_limit_sel = LIM_NONE;
      case (cur_mode_r)
         MD_AUTO_DCP:
         begin
            if (pw_sel)
            begin
               out_nxt.current_limit_sel = load_present_pw ? LIM_HIGH : LIM_WAKE;
               out_nxt.status_n          = !load_present_pw;
            end
            else
            begin
               out_nxt.current_limit_sel = LIM_HIGH;
               out_nxt.status_n          = !(npw_sel && load_present_npw);
            end
         end
         MD_SHORTED, MD_DIVIDER_ONE_SCHEME, MD_SDP_A:
            out_nxt.current_limit_sel = pins.limit_pick ? LIM_HIGH : LIM_LOW;
         MD_SDP_B:
            out_nxt.current_limit_sel = LIM_LOW;
         MD_CDP:
         begin
            out_nxt.current_limit_sel = LIM_HIGH;
            out_nxt.status_n          = !(load_present_npw || primary_detect);
         end
         default:
            out_nxt.current_limit_sel = LIM_NONE;
      endcase
      if (!out_nxt.power_switch_on)
      begin
         out_nxt.current_limit_sel = LIM_NONE;
         out_nxt.status_n          = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         port_out    <= '{power_switch_on: 1'b0, discharge_on: 1'b1, data_switch_on: 1'b0,
                          current_limit_sel: LIM_NONE, status_n: 1'b1};
         mode        <= MD_DISCHARGE;
         prev_mode_r <= MD_DISCHARGE;
      end
      else
      begin
         port_out    <= out_nxt;
         mode        <= cur_mode_r;
         prev_mode_r <= cur_mode_r;
      end
   end

   // Sticky event bits; a new event wins over a clear in the same cycle.
   assign irq_ev[IRQ_DCHG_BIT] = tmr_done;
   assign irq_ev[IRQ_FB_BIT]   = fb_trig;
   assign irq_ev[IRQ_MODE_BIT] = cur_mode_r != prev_mode_r;
   assign wr_clr = avs_write && avs_byteenable[0] && avs_address == OFS_IRQ_CLR;

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         irq_stat_r <= '0;
      else
         irq_stat_r <= (irq_stat_r & ~(wr_clr ? avs_writedata[IRQ_W-1:0] : '0)) | irq_ev;
   end

   assign irq = |(irq_stat_r & irq_en_r);

   // Register writes complete in the cycle they are presented.
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         fb_en_r  <= CTRL_FB_EN_RST;
         irq_en_r <= IRQ_EN_RST;
      end
      else if (avs_write && avs_byteenable[0])
      begin
         if (avs_address == OFS_CTRL)
            fb_en_r <= avs_writedata[CTRL_FB_EN_BIT];
         if (avs_address == OFS_IRQ_EN)
            irq_en_r <= avs_writedata[IRQ_W-1:0];
      end
   end

   always_comb
   begin
      case (avs_address)
         OFS_CTRL:     rd_nxt = {31'h0, fb_en_r};
         OFS_STATE:    rd_nxt = {18'h0, fb_active_r, state_r, port_out, 1'b0, cur_mode_r};
         OFS_IRQ_STAT: rd_nxt = {29'h0, irq_stat_r};
         OFS_IRQ_EN:   rd_nxt = {29'h0, irq_en_r};
         default:      rd_nxt = 32'h0;
      endcase
   end

   // Reads take one wait cycle so that read data come from a register.
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         rd_done_r    <= 1'b0;
         avs_readdata <= 32'h0;
      end
      else
      begin
         rd_done_r <= avs_read && !rd_done_r;
         if (avs_read && !rd_done_r)
            avs_readdata <= rd_nxt;
      end
   end

   assign avs_waitrequest = avs_read && !rd_done_r;

   localparam int A_LONG  = DCHG_LONG_CYC;
   localparam int A_SHORT = DCHG_SHORT_CYC;

   init_hold_a: assert property (@(posedge clk) state_r == ST_INIT |=> port_out.discharge_on && !port_out.power_switch_on)
      else $error("output not discharging in initial state");
   init_leave_a: assert property (@(posedge clk) disable iff (!rst_sync_n) state_r == ST_INIT |=> state_r == ST_RUN)
      else $error("initial state not left after reset");
   zero_pins_a: assert property (@(posedge clk) disable iff (!rst_sync_n) state_r == ST_RUN && req_mode == MD_DISCHARGE |=> cur_mode_r == MD_DISCHARGE ##1 (port_out.discharge_on && port_out.status_n))
      else $error("pins 000 did not discharge output");
   forced_limit_a: assert property (@(posedge clk) disable iff (!rst_sync_n) state_r == ST_RUN && (cur_mode_r == MD_SHORTED || cur_mode_r == MD_DIVIDER_ONE_SCHEME) |=> port_out.status_n && port_out.current_limit_sel == ($past(pins.limit_pick) ? LIM_HIGH : LIM_LOW))
      else $error("forced scheme limit or status wrong");
   wake_limit_a: assert property (@(posedge clk) disable iff (!rst_sync_n) state_r == ST_RUN && cur_mode_r == MD_AUTO_DCP && pw_sel && !load_present_pw |=> port_out.current_limit_sel == LIM_WAKE && port_out.status_n)
      else $error("wake limit not applied without load");
   pw_status_a: assert property (@(posedge clk) disable iff (!rst_sync_n) state_r == ST_RUN && cur_mode_r == MD_AUTO_DCP && pw_sel && load_present_pw |=> !port_out.status_n && port_out.current_limit_sel == LIM_HIGH)
      else $error("power wake load status missing");
   cdp_status_a: assert property (@(posedge clk) disable iff (!rst_sync_n) state_r == ST_RUN && cur_mode_r == MD_CDP && (load_present_npw || primary_detect) |=> !port_out.status_n && port_out.current_limit_sel == LIM_HIGH)
      else $error("downstream status not asserted");
   swap_no_dchg_a: assert property (@(posedge clk) disable iff (!rst_sync_n) state_r == ST_RUN && cur_mode_r == MD_SDP_B && want_mode == MD_CDP |=> state_r == ST_RUN && cur_mode_r == MD_CDP)
      else $error("swap between 1110 and 1111 discharged");
   long_dchg_a: assert property (@(posedge clk) disable iff (!rst_sync_n) tmr_start && tmr_long |-> ##A_LONG state_r == ST_DCHG ##1 state_r == ST_RUN)
      else $error("long discharge length wrong");
   short_dchg_a: assert property (@(posedge clk) disable iff (!rst_sync_n) tmr_start && !tmr_long |-> ##A_SHORT state_r == ST_DCHG ##1 state_r == ST_RUN)
      else $error("short discharge length wrong");
   dchg_open_a: assert property (@(posedge clk) disable iff (!rst_sync_n) state_r == ST_DCHG |=> !port_out.power_switch_on && !port_out.data_switch_on)
      else $error("switch closed during discharge");
   fb_start_a: assert property (@(posedge clk) disable iff (!rst_sync_n) fb_trig && req_mode == MD_CDP |-> ##[1:2] (state_r == ST_DCHG && tgt_mode_r == MD_SDP_A))
      else $error("fallback discharge not started");
   fb_return_a: assert property (@(posedge clk) disable iff (!rst_sync_n) fb_active_r && state_r == ST_RUN && cur_mode_r == MD_SDP_A && data_attach && req_mode == MD_CDP |-> ##1 (state_r == ST_RUN)[*2] ##0 cur_mode_r == MD_CDP)
      else $error("fallback return not direct");
   data_enable_a: assert property (@(posedge clk) disable iff (!rst_sync_n) port_out.data_switch_on |-> $past(enable) && $past(cur_data_mode))
      else $error("data switch closed without enable");

   long_dchg_c: cover property (@(posedge clk) disable iff (!rst_sync_n) tmr_start && tmr_long);
   fb_cycle_c: cover property (@(posedge clk) disable iff (!rst_sync_n) fb_return_r && cur_mode_r == MD_CDP);
   swap_c: cover property (@(posedge clk) disable iff (!rst_sync_n) cur_mode_r == MD_SDP_B ##1 cur_mode_r == MD_CDP);
   irq_c: cover property (@(posedge clk) disable iff (!rst_sync_n) irq);

endmodule

// *** cpm_pkg.sv ***
// Package with shared constants, types and register map of the charging port mode control block.
package cpm_pkg;

   // Clock and timing.
   localparam int CLK_PERIOD_NS      = 10;
   localparam int DCHG_LONG_NS       = 2000;
   localparam int DCHG_SHORT_NS      = 500;
   localparam int FB_WAIT_NS         = 5000;
   localparam int DCHG_LONG_CYC      = (DCHG_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DCHG_SHORT_CYC     = (DCHG_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FB_WAIT_CYC        = (FB_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] DCHG_LONG_CNT  = 8'(DCHG_LONG_CYC);
   localparam logic [7:0] DCHG_SHORT_CNT = 8'(DCHG_SHORT_CYC);
   localparam logic [9:0] FB_WAIT_CNT    = 10'(FB_WAIT_CYC);

   // Register byte offsets.
   localparam logic [4:0] OFS_CTRL      = 5'h00;
   localparam logic [4:0] OFS_STATE     = 5'h04;
   localparam logic [4:0] OFS_IRQ_STAT  = 5'h08;
   localparam logic [4:0] OFS_IRQ_CLR   = 5'h0C;
   localparam logic [4:0] OFS_IRQ_EN    = 5'h10;

   // Field positions and reset values.
   localparam int CTRL_FB_EN_BIT      = 0;
   localparam logic CTRL_FB_EN_RST    = 1'b1;
   localparam int IRQ_W               = 3;
   localparam int IRQ_DCHG_BIT        = 0;
   localparam int IRQ_FB_BIT          = 1;
   localparam int IRQ_MODE_BIT        = 2;
   localparam logic [2:0] IRQ_EN_RST  = 3'h0;

   typedef enum logic [2:0] {
      MD_DISCHARGE,
      MD_AUTO_DCP,
      MD_SHORTED,
      MD_DIVIDER_ONE_SCHEME,
      MD_SDP_A,
      MD_SDP_B,
      MD_CDP
   } cpm_mode_t;

   typedef enum logic [1:0] {
      LIM_NONE,
      LIM_LOW,
      LIM_HIGH,
      LIM_WAKE
   } cpm_limit_t;

   typedef struct packed {
      logic mode_select_a;
      logic mode_select_b;
      logic mode_select_c;
      logic limit_pick;
   } cpm_pins_t;

   typedef struct packed {
      logic       power_switch_on;
      logic       discharge_on;
      logic       data_switch_on;
      cpm_limit_t current_limit_sel;
      logic       status_n;
   } cpm_port_out_t;

endpackage

// *** cpm_dchg_timer.sv ***
// Discharge duration timer with long and short lengths.
module cpm_dchg_timer
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Control.
   input  wire logic start,
   input  wire logic long_sel,
   // Status.
   output logic      busy,
   output logic      done
);
   import cpm_pkg::*;

   logic [7:0] cnt_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_r <= 8'h00;
      else if (start)
         cnt_r <= long_sel ? DCHG_LONG_CNT : DCHG_SHORT_CNT;
      else if (cnt_r != 8'h00)
         cnt_r <= cnt_r - 8'h01;
   end

   assign busy = (cnt_r != 8'h00);
   assign done = (cnt_r == 8'h01);

endmodule

// *** cpm_phone_model.sv ***
// Behavioural model of a portable phone on VBUS and the data lines.
module cpm_phone_model
(
   // Clock.
   input  wire logic       clk,
   // Port state seen by the phone.
   input  wire logic       vbus,
   input  wire logic       dsw,
   // Phone behaviour chosen by the bench.
   input  wire logic       att,
   input  wire logic       heavy,
   input  wire logic       draw,
   input  wire logic       shy,
   input  wire logic [3:0] lag,
   // Detection results.
   output logic            pw,
   output logic            npw,
   output logic            pd,
   output logic            dat
);
   logic       refuse_r;
   logic [3:0] cnt_r;
   logic       ok;

   assign ok = att && vbus && dsw && !refuse_r;
   assign pw = att && heavy && vbus;
   assign npw = att && draw && vbus;
   assign pd = att && vbus;
   assign dat = ok && cnt_r == lag;

   // A shy phone takes the port for a charger and makes no data connection until VBUS drops once.
   always_ff @(posedge clk)
   begin
      if (!att)
         refuse_r <= shy;
      else if (!vbus)
         refuse_r <= 1'b0;
      if (!ok)
         cnt_r <= 4'h0;
      else if (cnt_r != lag)
         cnt_r <= cnt_r + 4'h1;
   end
endmodule

// *** charging_port_mode_control_test.sv ***
// Self-checking bench for the charging port mode control block.
module charging_port_mode_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cpm_pkg::*;

   cpm_pins_t     pins;
   cpm_port_out_t port_out;
   cpm_mode_t     mode;
   logic          clk, rst_n, enable, irq, pw, npw, pd, dat, att, hv, dr, shy;
   logic [3:0]    lag;
   logic [4:0]    avs_address;
   logic          avs_read, avs_write, avs_waitrequest;
   logic [31:0]   avs_writedata, avs_readdata, q;
   int            seed, fails, tests_run, n;

   always #5 clk = ~clk;

   cpm_mode_ctrl cpm_mode_ctrl_inst
   (
      .clk(clk), .rst_n(rst_n), .pins(pins), .enable(enable), .load_present_pw(pw),
      .load_present_npw(npw), .primary_detect(pd), .data_attach(dat), .port_out(port_out),
      .mode(mode), .irq(irq), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest)
   );

   cpm_phone_model cpm_phone_model_inst
   (
      .clk(clk), .vbus(port_out.power_switch_on), .dsw(port_out.data_switch_on), .att(att),
      .heavy(hv), .draw(dr), .shy(shy), .lag(lag), .pw(pw), .npw(npw), .pd(pd), .dat(dat)
   );

   function automatic cpm_mode_t exp_mode(logic [3:0] p);
      case (p[3:1])
         3'b000: return MD_DISCHARGE;
         3'b001, 3'b011: return MD_AUTO_DCP;
         3'b100: return MD_SHORTED;
         3'b101: return MD_DIVIDER_ONE_SCHEME;
         3'b111: return p[0] ? MD_CDP : MD_SDP_B;
         default: return MD_SDP_A;
      endcase
   endfunction

   function automatic cpm_port_out_t exp_out(logic [3:0] p, logic en, logic w, logic l, logic s);
      cpm_port_out_t o;
      cpm_mode_t     m;
      m = exp_mode(p);
      o.power_switch_on = m != MD_DISCHARGE;
      o.discharge_on = m == MD_DISCHARGE;
      o.data_switch_on = en && (m == MD_SDP_A || m == MD_SDP_B || m == MD_CDP);
      o.current_limit_sel = m == MD_DISCHARGE ? LIM_NONE : p[0] ? LIM_HIGH : LIM_LOW;
      if (!p[3] && p[1])
         o.current_limit_sel = (!p[2] && p[0] && !w) ? LIM_WAKE : LIM_HIGH;
      o.status_n = !(p[0] && p[1] && (p[3:2] == 2'b00 ? w : p[3:2] == 2'b01 ? l : p[3:2] == 2'b11 && (l || s)));
      return o;
   endfunction

   task automatic results;
      $display("Counts: %0d compared, %0d failed", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic fail(string m);
      fails++;
      $display("Error at %0t: %s", $time, m);
   endtask

   task automatic chk_w(logic [31:0] g, logic [31:0] e);
      tests_run++;
      if (g !== e)
         fail($sformatf("got %h expected %h", g, e));
   endtask

   task automatic chk_n(int g, int e);
      tests_run++;
      if (g != e)
         fail($sformatf("count %0d expected %0d", g, e));
   endtask

   task automatic chk_port(logic [3:0] p);
      chk_w(32'(mode), 32'(exp_mode(p)));
      chk_w(32'(port_out), 32'(exp_out(p, enable, att & hv, att & dr, att)));
   endtask

   task automatic chk_irq(logic e);
      @(negedge clk);
      chk_w(32'(irq), 32'(e));
   endtask

   task automatic bus(logic wr, logic [4:0] a, logic [31:0] d);
      logic w;
      int   k;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      k = 0;
      // Waitrequest and read data are taken at the rising edge itself, before it updates the slave.
      do
      begin
         @(posedge clk);
         w = avs_waitrequest;
         q = avs_readdata;
         k++;
      end
      while (w && k < 20);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (w)
      begin
         fail("bus timeout");
         results();
      end
   endtask

   task automatic go(logic [3:0] p);
      @(posedge clk);
      pins <= cpm_pins_t'(p);
   endtask

   task automatic wait_mode(cpm_mode_t m);
      int k;
      k = 0;
      while (mode !== m && k < 300)
      begin
         @(negedge clk);
         k++;
      end
      if (mode !== m)
      begin
         fail("mode wait");
         results();
      end
      repeat (5) @(negedge clk);
   endtask

   // Counts cycles with the power switch off; the data switch must stay open meanwhile.
   task automatic off_cycles(int lim);
      n = 0;
      repeat (lim)
      begin
         @(negedge clk);
         if (!port_out.power_switch_on)
            n++;
         if (!port_out.power_switch_on && port_out.data_switch_on)
            fail("data switch on");
      end
   endtask

   initial
   begin
      clk = 0;
      rst_n = 0;
      pins = cpm_pins_t'(4'hF);
      {enable, att, hv, dr, shy, avs_read, avs_write} = '0;
      avs_address = '0;
      avs_writedata = '0;
      lag = 4'h1;
      seed = 63260;
      repeat (16) @(posedge clk);
      chk_port(4'h0);
      rst_n <= 1'b1;
      wait_mode(MD_CDP);
      bus(0, OFS_CTRL, 0);
      chk_w(q, 32'h1);
      bus(0, OFS_IRQ_EN, 0);
      chk_w(q, 32'h0);
      bus(1, 5'h14, 32'hFFFFFFFF);
      bus(0, 5'h14, 0);
      chk_w(q, 32'h0);
      $display("Test done: reset and registers");
      for (int i = 0; i < 48; i++)
      begin
         go(4'h0);
         enable <= 1'($random(seed));
         att    <= 1'($random(seed));
         hv     <= 1'($random(seed));
         dr     <= 1'($random(seed));
         wait_mode(MD_DISCHARGE);
         go(4'(i));
         wait_mode(exp_mode(4'(i)));
         chk_port(4'(i));
      end
      $display("Test done: truth table");
      enable <= 1'b1;
      att    <= 1'b0;
      go(4'hF);
      wait_mode(MD_CDP);
      bus(1, OFS_IRQ_CLR, 32'h7);
      bus(1, OFS_IRQ_EN, 32'h1);
      go(4'h3);
      off_cycles(400);
      chk_n(n, DCHG_LONG_CYC);
      chk_port(4'h3);
      chk_irq(1'b1);
      bus(1, OFS_IRQ_EN, 32'h0);
      chk_irq(1'b0);
      bus(1, OFS_IRQ_CLR, 32'h1);
      bus(1, OFS_IRQ_EN, 32'h1);
      chk_irq(1'b0);
      bus(0, OFS_IRQ_CLR, 0);
      chk_w(q, 32'h0);
      go(4'hF);
      off_cycles(200);
      chk_n(n, DCHG_SHORT_CYC);
      for (int i = 0; i < 2; i++)
      begin
         go(4'hE ^ 4'(i));
         off_cycles(20);
         chk_n(n, 0);
         chk_port(4'hE ^ 4'(i));
      end
      $display("Test done: discharge timing and interrupt");
      for (int i = 0; i < 2; i++)
      begin
         if (i == 1)
            bus(1, OFS_CTRL, 32'h0);
         @(posedge clk);
         shy <= 1'b1;
         att <= 1'b0;
         lag <= 4'(($random(seed) & 7) + 1);
         @(posedge clk);
         att <= 1'b1;
         off_cycles(700);
         chk_n(n, i ? 0 : DCHG_SHORT_CYC);
         chk_w(32'(mode), 32'(MD_CDP));
      end
      att <= 1'b0;
      bus(0, OFS_IRQ_STAT, 0);
      chk_w(32'(q[IRQ_W-1:0]), 32'h7);
      $display("Test done: data-only fallback");
      @(posedge clk);
      rst_n <= 1'b0;
      @(negedge clk);
      chk_port(4'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      wait_mode(MD_CDP);
      chk_port(4'hF);
      $display("Test done: reset in mid-run");
      results();
   end
endmodule
